// ==== mtlc_pkg.sv ====
// constants, field positions and types for the trap and link control block
// assumes bit 0 of every vector is the least significant bit; the printed
// big-endian bit numbers are mapped onto these positions here only
package mtlc_pkg;

  // ==========================================================
  // address fields
  localparam int unsigned NA_W       = 12;  // next address width
  localparam int unsigned NIB_W      = 4;   // link register width
  localparam int unsigned LINK_N     = 8;   // number of link registers
  localparam int unsigned LINK_SEL_W = 3;
  localparam int unsigned FX_W       = 4;
  localparam int unsigned MERGE_BIT  = 4;   // printed next address bit 7
  localparam int unsigned PAGE_LSB   = 8;   // printed bits 0 to 3
  localparam logic [3:0]  LINK_FX_MAX = 4'h7;
  localparam logic [11:0] TRAP_VECTOR = 12'h000;
  localparam logic [1:0]  REFILL_HI   = 2'h1;  // top two bits: 0,1

  // ==========================================================
  // buffer fill pointer codes, bit 0 is the printed pointer bit 1
  localparam logic [1:0] PTR_EMPTY = 2'h0;
  localparam logic [1:0] PTR_BYTE  = 2'h1;
  localparam logic [1:0] PTR_WORD  = 2'h3;
  localparam logic [1:0] PTR_FULL  = 2'h2;

  // ==========================================================
  // error kinds, smaller code reported first
  localparam int unsigned EK_N       = 4;
  localparam logic [1:0]  EK_MEMORY  = 2'h0;
  localparam logic [1:0]  EK_PARITY  = 2'h1;
  localparam logic [1:0]  EK_STACK   = 2'h2;
  localparam logic [1:0]  EK_BUFFER  = 2'h3;
  localparam int unsigned XBUS_W     = 16;
  localparam int unsigned EK_XPOS    = 6;   // printed x bus bits 8 to 9

  // ==========================================================
  // tasks and stack
  localparam int unsigned TASK_W      = 3;
  localparam logic [2:0]  TASK_EMU    = 3'h0;
  localparam logic [2:0]  TASK_KERNEL = 3'h7;
  localparam int unsigned STK_W       = 4;
  localparam logic [3:0]  STK_BOTTOM  = 4'h0;
  localparam logic [3:0]  STK_NEXT    = 4'h1;
  localparam logic [3:0]  STK_TOP     = 4'hf;
  localparam logic [3:0]  STK_STEP    = 4'h1;

  // ==========================================================
  // cycle within a click, gray along c1 c2 c3
  typedef enum logic [1:0] {
    MTLC_C1 = 2'b00,
    MTLC_C2 = 2'b01,
    MTLC_C3 = 2'b11
  } mtlc_phase_e;

endpackage

// ==== mtlc_click_phase.sv ====
// three-cycle click sequencer for the trap and link control block
// assumes a single clock, one microinstruction per cycle
`timescale 1ns/100ps

module mtlc_click_phase
  import mtlc_pkg::*;
(
  input  wire logic  core_clk_in,
  input  wire logic  reset_in,
  output mtlc_phase_e phase_out
);

  // ==========================================================
  // c1, c2, c3 then c1 again, never altered
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      phase_out <= MTLC_C1;
    end else begin
      case (phase_out)
        MTLC_C1: phase_out <= MTLC_C2;
        MTLC_C2: phase_out <= MTLC_C3;
        MTLC_C3: phase_out <= MTLC_C1;
        default: phase_out <= MTLC_C1;
      endcase
    end
  end

endmodule

// ==== mtlc_trap_pend.sv ====
// one pending error trap with an optional one-click deferral
// assumes click_end_in pulses in c3 and take_in only when ready_out is high
`timescale 1ns/100ps

module mtlc_trap_pend (
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  input  wire logic raise_in,
  input  wire logic delay_in,
  input  wire logic click_end_in,
  input  wire logic count_in,
  input  wire logic take_in,
  output logic      armed_out,
  output logic      ready_out
);

  logic need_click;
  logic fresh;  // raised inside the click that is still running

  // ==========================================================
  // a new error wins over the take in the same cycle; the click in
  // which the error was raised never counts as the owed click
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      armed_out  <= 1'b0;
      need_click <= 1'b0;
      fresh      <= 1'b0;
    end else if (raise_in) begin
      armed_out  <= 1'b1;
      need_click <= delay_in | need_click & armed_out;
      fresh      <= ~click_end_in;
    end else if (take_in) begin
      armed_out  <= 1'b0;
      need_click <= 1'b0;
      fresh      <= 1'b0;
    end else if (click_end_in) begin
      fresh <= 1'b0;
      if (count_in && !fresh) begin
        need_click <= 1'b0;
      end
    end
  end

  // ready in the c3 that ends the owed click, so the trap lands in c1
  assign ready_out = armed_out & ~raise_in
                   & (~need_click | click_end_in & count_in & ~fresh);

endmodule

// ==== mtlc_trap_link.sv ====
// next-address trap, link register and error-kind logic of the
// microsequencer; branch conditions, scheduling and the instruction
// buffer sit outside and arrive already decoded as strobes, branch bits, front byte and fill pointer
`timescale 1ns/100ps

module mtlc_trap_link
  import mtlc_pkg::*;
(
  input  wire logic                core_clk_in,
  input  wire logic                reset_in,
  input  wire logic [NA_W-1:0]     goto_field_in,
  input  wire logic [NIB_W-1:0]    branch_bits_in,
  input  wire logic [FX_W-1:0]     x_function_field_in,
  input  wire logic                interrupt_request_op_in,
  input  wire logic                clear_interrupt_error_op_in,
  input  wire logic                buffer_dispatch_in,
  input  wire logic                forced_buffer_dispatch_in,
  input  wire logic [7:0]          buffer_front_byte_in,
  input  wire logic [1:0]          buffer_fill_pointer_in,
  input  wire logic                buffer_read_op_in,
  input  wire logic                memory_address_load_in,
  input  wire logic                page_crossing_in,
  input  wire logic                memory_data_read_in,
  input  wire logic                memory_double_error_in,
  input  wire logic [TASK_W-1:0]   current_task_in,
  input  wire logic                control_parity_bad_in,
  input  wire logic                task_switch_in,
  input  wire logic [NA_W-1:0]     saved_next_address_in,
  input  wire logic                read_error_pointer_op_in,
  input  wire logic                x_field_pop_in,
  input  wire logic                z_field_pop_in,
  input  wire logic                push_in,
  output logic [NA_W-1:0]          next_address_out,
  output mtlc_phase_e              cycle_phase_out,
  output logic                     trap_valid_out,
  output logic [TASK_W-1:0]        trap_task_out,
  output logic                     macro_interrupt_flag_out,
  output logic                     cs_parity_error_out,
  output logic [XBUS_W-1:0]        x_bus_out,
  output logic                     x_bus_oe_out,
  output logic [STK_W-1:0]         stack_index_out,
  output logic                     buffer_dispatch_done_out
);

  // ==========================================================
  // click sequencing
  logic is_c1;
  logic click_end;
  logic is_emu;

  mtlc_click_phase u_phase (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .phase_out   (cycle_phase_out)
  );

  assign is_c1     = cycle_phase_out == MTLC_C1;
  assign click_end = cycle_phase_out == MTLC_C3;
  assign is_emu    = current_task_in == TASK_EMU;

  // ==========================================================
  // error detection
  logic [EK_N-1:0] err_raise;
  logic [EK_N-1:0] err_delay;
  logic [EK_N-1:0] err_count;
  logic [EK_N-1:0] err_armed;
  logic [EK_N-1:0] err_ready;
  logic [EK_N-1:0] err_take;
  logic            stk_trap;
  logic            buf_empty_err;
  logic            trap_take;

  assign buf_empty_err = buffer_read_op_in
                       && buffer_fill_pointer_in == PTR_EMPTY;

  // raise conditions and the owed click for each kind
  always_comb begin
    err_raise[EK_MEMORY] = memory_double_error_in && memory_data_read_in
                        && click_end && is_emu;
    err_delay[EK_MEMORY] = 1'b1;
    err_count[EK_MEMORY] = is_emu;
    err_raise[EK_PARITY] = control_parity_bad_in;
    err_delay[EK_PARITY] = ~is_c1;
    err_count[EK_PARITY] = 1'b1; // any task may fill the gap
    err_raise[EK_STACK]  = stk_trap;
    err_delay[EK_STACK]  = 1'b1;
    err_count[EK_STACK]  = is_emu;
    err_raise[EK_BUFFER] = buf_empty_err;
    err_delay[EK_BUFFER] = ~is_c1;
    err_count[EK_BUFFER] = is_emu;
  end

  // one pending trap per kind, errors can never be masked
  genvar gi;
  generate
    for (gi = 0; gi < EK_N; gi++) begin : g_pend
      mtlc_trap_pend u_pend (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .raise_in     (err_raise[gi]),
        .delay_in     (err_delay[gi]),
        .click_end_in (click_end),
        .count_in     (err_count[gi]),
        .take_in      (err_take[gi]),
        .armed_out    (err_armed[gi]),
        .ready_out    (err_ready[gi])
      );
    end
  endgenerate

  // trap only from c3 so vector 0 runs in c1
  assign trap_take = click_end && |err_ready;
  assign err_take  = trap_take ? err_ready : '0;

  // ==========================================================
  // accumulated error kinds, set wins over clear
  logic [EK_N-1:0] ek_seen;
  logic [1:0]      ek_code;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ek_seen <= '0;
    end else if (clear_interrupt_error_op_in) begin
      ek_seen <= err_raise;
    end else begin
      ek_seen <= ek_seen | err_raise;
    end
  end

  // smallest code present is reported
  always_comb begin
    ek_code = EK_BUFFER;
    if (ek_seen[EK_STACK])  ek_code = EK_STACK;
    if (ek_seen[EK_PARITY]) ek_code = EK_PARITY;
    if (ek_seen[EK_MEMORY]) ek_code = EK_MEMORY;
  end

  // x bus read, one cycle after the read strobe
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      x_bus_out    <= '0;
      x_bus_oe_out <= 1'b0;
    end else begin
      x_bus_out    <= '0;
      x_bus_oe_out <= read_error_pointer_op_in;
      if (read_error_pointer_op_in) begin
        x_bus_out[EK_XPOS +: 2] <= ek_code;
      end
    end
  end

  // ==========================================================
  // macro-interrupt flag, request wins over clear
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      macro_interrupt_flag_out <= 1'b0;
    end else if (interrupt_request_op_in) begin
      macro_interrupt_flag_out <= 1'b1;
    end else if (clear_interrupt_error_op_in) begin
      macro_interrupt_flag_out <= 1'b0;
    end
  end

  // parity indication held one cycle for the io processor to sample
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cs_parity_error_out <= 1'b0;
    end else begin
      cs_parity_error_out <= control_parity_bad_in;
    end
  end

  // ==========================================================
  // stack index and overflow or underflow check
  logic [STK_W-1:0] next_stack;

  always_comb begin
    next_stack = stack_index_out;
    stk_trap   = 1'b0;
    case ({x_field_pop_in, z_field_pop_in, push_in})
      3'b100, 3'b010: begin
        next_stack = stack_index_out - STK_STEP;
        stk_trap   = stack_index_out == STK_BOTTOM;
      end
      3'b001: begin
        next_stack = stack_index_out + STK_STEP;
        stk_trap   = stack_index_out == STK_TOP;
      end
      3'b101: stk_trap = stack_index_out == STK_BOTTOM;
      3'b011: stk_trap = stack_index_out == STK_TOP;
      3'b110: begin
        next_stack = stack_index_out - STK_STEP;
        stk_trap   = stack_index_out == STK_BOTTOM
                  || stack_index_out == STK_NEXT;
      end
      3'b111: begin
        stk_trap = stack_index_out == STK_BOTTOM
                || stack_index_out == STK_NEXT;
      end
      default: next_stack = stack_index_out;
    endcase
  end

  // index moves even when the trap is raised
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      stack_index_out <= STK_BOTTOM;
    end else begin
      stack_index_out <= next_stack;
    end
  end

  // ==========================================================
  // link registers
  logic [NIB_W-1:0]      link_state [LINK_N];
  logic [LINK_SEL_W-1:0] link_sel;
  logic                  link_hit;
  logic                  link_write;
  logic                  link_merge;
  logic [NA_W-1:0]       saved_next_address;

  assign link_sel   = x_function_field_in[LINK_SEL_W-1:0];
  assign link_hit   = x_function_field_in <= LINK_FX_MAX;
  assign link_write = link_hit && !next_address_out[MERGE_BIT];
  assign link_merge = link_hit && next_address_out[MERGE_BIT];
  assign saved_next_address = task_switch_in ? saved_next_address_in
                                             : next_address_out;

  // store the low nibble of the saved address
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < LINK_N; i++) begin
        link_state[i] <= '0;
      end
    end else if (link_write) begin
      link_state[link_sel] <= saved_next_address[NIB_W-1:0];
    end
  end

  // ==========================================================
  // next address: goto, branch, link, buffer dispatch, traps
  logic            cancel_buf;
  logic            refill_trap;
  logic            dispatch_go;
  logic [NA_W-1:0] next_na;

  // page cross or empty error in the previous instruction
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cancel_buf <= 1'b0;
    end else begin
      cancel_buf <= memory_address_load_in && page_crossing_in
                 || buf_empty_err;
    end
  end

  assign refill_trap = buffer_dispatch_in && !forced_buffer_dispatch_in
                    && !cancel_buf
                    && (buffer_fill_pointer_in != PTR_FULL
                        || macro_interrupt_flag_out);
  assign dispatch_go = (buffer_dispatch_in || forced_buffer_dispatch_in)
                    && !cancel_buf && !refill_trap;

  always_comb begin
    next_na = goto_field_in;
    next_na[NIB_W-1:0] = goto_field_in[NIB_W-1:0] | branch_bits_in;
    if (link_merge) begin
      next_na[NIB_W-1:0] = next_na[NIB_W-1:0]
                         | link_state[link_sel];
    end
    if (dispatch_go) begin
      next_na[7:4] = buffer_front_byte_in[7:4];
      next_na[3:0] = next_na[3:0] | buffer_front_byte_in[3:0];
    end
    if (refill_trap) begin
      // slot 4..7 from flag and pointer bit, low byte untouched
      next_na[NA_W-1:PAGE_LSB] = {REFILL_HI, macro_interrupt_flag_out,
                                  buffer_fill_pointer_in[0]};
    end
    if (trap_take) begin
      next_na = TRAP_VECTOR;
    end
  end

  // address register and trap report
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      next_address_out         <= TRAP_VECTOR;
      trap_valid_out           <= 1'b0;
      trap_task_out            <= TASK_EMU;
      buffer_dispatch_done_out <= 1'b0;
    end else begin
      next_address_out         <= next_na;
      trap_valid_out           <= trap_take;
      buffer_dispatch_done_out <= dispatch_go && !trap_take;
      if (trap_take) begin
        // parity runs the kernel, the rest the emulator
        trap_task_out <= err_ready[EK_PARITY] ? TASK_KERNEL
                                              : TASK_EMU;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_par_c1;
    control_parity_bad_in && is_c1 && !(|err_armed);
  endsequence

  sequence s_kernel_start;
    trap_take ##1 (next_address_out == TRAP_VECTOR
                   && trap_task_out == TASK_KERNEL);
  endsequence

  property p_parity_c1;
    s_par_c1 |-> ##2 s_kernel_start;
  endproperty
  a_parity_c1: assert property (p_parity_c1)
    else $error("parity in c1 did not trap kernel next c1");

  property p_flag_set;
    interrupt_request_op_in |=> macro_interrupt_flag_out;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("interrupt flag not set");

  property p_clear;
    clear_interrupt_error_op_in && !interrupt_request_op_in
      && !(|err_raise) |=> !macro_interrupt_flag_out && ek_seen == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left flag or error kinds");

  property p_link_write;
    link_write |=> link_state[$past(link_sel)]
                   == $past(saved_next_address[NIB_W-1:0]);
  endproperty
  a_link_write: assert property (p_link_write)
    else $error("link register not loaded");

  property p_trap_zero;
    trap_take |=> next_address_out == TRAP_VECTOR && trap_valid_out
                  && cycle_phase_out == MTLC_C1;
  endproperty
  a_trap_zero: assert property (p_trap_zero)
    else $error("error trap did not land at zero in c1");

  property p_refill;
    refill_trap && !trap_take |=>
      next_address_out[NA_W-1:PAGE_LSB] ==
        {REFILL_HI, $past(macro_interrupt_flag_out),
         $past(buffer_fill_pointer_in[0])};
  endproperty
  a_refill: assert property (p_refill)
    else $error("refill trap slot wrong");

  property p_forced;
    forced_buffer_dispatch_in |-> !refill_trap;
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced dispatch raised a refill trap");

  property p_min_kind;
    ek_seen[EK_MEMORY] |-> ek_code == EK_MEMORY;
  endproperty
  a_min_kind: assert property (p_min_kind)
    else $error("error kind not the smallest");

  property p_overflow;
    push_in && !x_field_pop_in && !z_field_pop_in
      && stack_index_out == STK_TOP
      |=> stack_index_out == STK_BOTTOM && err_armed[EK_STACK];
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("push at top did not wrap and arm trap");

  property p_mem_device;
    memory_double_error_in && !is_emu && !err_armed[EK_MEMORY]
      |=> !err_armed[EK_MEMORY];
  endproperty
  a_mem_device: assert property (p_mem_device)
    else $error("memory trap armed for a device task");

endmodule

// ==== mtlc_far_model.sv ====
// far side model: buffer pointer source and memory error reporter
// assumes phase_in comes from the block under test, one clock domain
`timescale 1ns/100ps

module mtlc_far_model
  import mtlc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire mtlc_phase_e phase_in,
  input  wire logic [1:0]  ptr_set_in,
  input  wire logic        mem_err_req_in,
  output logic [1:0]       buffer_fill_pointer_out,
  output logic             memory_data_read_out,
  output logic             memory_double_error_out
);
  logic pend;

  // ==========================================================
  // buffer pointer, registered like the real buffer state
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      buffer_fill_pointer_out <= PTR_EMPTY;
    end else begin
      buffer_fill_pointer_out <= ptr_set_in;
    end
  end

  // ==========================================================
  // a requested error waits for c3, the only cycle data returns
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pend <= 1'b0;
    end else if (mem_err_req_in) begin
      pend <= 1'b1;
    end else if (memory_data_read_out) begin
      pend <= 1'b0;
    end
  end

  // read strobe and double error together in c3 only
  assign memory_data_read_out    = pend & (phase_in == MTLC_C3);
  assign memory_double_error_out = memory_data_read_out;
endmodule

// ==== mtlc_trap_link_tb.sv ====
// self-checking bench for the trap and link control block
// assumes the far side model drives the pointer and memory error inputs
`timescale 1ns/100ps

module mtlc_trap_link_tb
  import mtlc_pkg::*;
();
  logic        clk, rst, irq, clr, bd, fbd, brd, mal, pgc, par, tsw;
  logic        rde, xp, zp, psh, merr, tv, flag, cpe, xoe, done;
  logic        mdr, mde, nt;
  logic [11:0] goto, sna, na;
  logic [7:0]  fb;
  logic [3:0]  bb, xf, si;
  logic [2:0]  tsk, tt;
  logic [1:0]  ptr, ptr_set;
  logic [15:0] xb;
  mtlc_phase_e ph;
  int          err_count, total_checks, n;

  always #2 clk = ~clk;

  mtlc_trap_link u_dut (
    .core_clk_in(clk), .reset_in(rst), .goto_field_in(goto),
    .branch_bits_in(bb), .x_function_field_in(xf),
    .interrupt_request_op_in(irq), .clear_interrupt_error_op_in(clr),
    .buffer_dispatch_in(bd), .forced_buffer_dispatch_in(fbd),
    .buffer_front_byte_in(fb), .buffer_fill_pointer_in(ptr),
    .buffer_read_op_in(brd), .memory_address_load_in(mal),
    .page_crossing_in(pgc), .memory_data_read_in(mdr),
    .memory_double_error_in(mde), .current_task_in(tsk),
    .control_parity_bad_in(par), .task_switch_in(tsw),
    .saved_next_address_in(sna), .read_error_pointer_op_in(rde),
    .x_field_pop_in(xp), .z_field_pop_in(zp), .push_in(psh),
    .next_address_out(na), .cycle_phase_out(ph), .trap_valid_out(tv),
    .trap_task_out(tt), .macro_interrupt_flag_out(flag),
    .cs_parity_error_out(cpe), .x_bus_out(xb), .x_bus_oe_out(xoe),
    .stack_index_out(si), .buffer_dispatch_done_out(done)
  );

  mtlc_far_model u_far (
    .core_clk_in(clk), .reset_in(rst), .phase_in(ph),
    .ptr_set_in(ptr_set), .mem_err_req_in(merr),
    .buffer_fill_pointer_out(ptr), .memory_data_read_out(mdr),
    .memory_double_error_out(mde)
  );

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // inputs move 1 ns after the edge so sampling never races
  task automatic cyc(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // strobes low, x field out of link range
  task automatic idle();
    {irq, clr, bd, fbd, brd, mal, pgc, par, tsw, rde, xp, zp, psh, merr,
     bb, xf} = {18'h0, 4'h8};
  endtask

  task automatic to_phase(input mtlc_phase_e p);
    int k;
    k = 0;
    while (ph !== p && k < 4) begin
      cyc();
      k++;
    end
    chk(ph, p);
  endtask

  // n counts edges from the raising cycle to the trap cycle
  task automatic trap(input logic [2:0] t);
    n = 0;
    do begin
      cyc();
      idle();
      n++;
    end while (tv !== 1'b1 && n < 40);
    if (tv !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: no trap", $time);
      results();
    end else begin
      chk(na, TRAP_VECTOR);
      chk(tt, t);
      chk(ph, MTLC_C1);
    end
  endtask

  task automatic rd_kind(input logic [1:0] e);
    rde = 1'b1;
    cyc();
    rde = 1'b0;
    chk(xoe, 1'b1);
    chk(xb, {8'h00, e, 6'h00});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    idle();
    {goto, tsk, sna, ptr_set, fb} = '0;
    cyc(3);
    chk(flag, 1'b0);
    rst = 1'b0;
    irq = 1'b1;
    cyc();
    idle();
    chk(flag, 1'b1);
    // store link 3 from the saved address, then merge it
    {xf, tsw, sna, goto} = {4'h3, 1'b1, 12'h00a, 12'h010};
    cyc();
    {tsw, bb, goto} = {1'b0, 4'h1, 12'h050};
    cyc();
    idle();
    chk(na, 12'h05b);
    // every flag and pointer combination of a buffer dispatch
    {goto, fb} = {12'h3a1, 8'h5c};
    for (int f = 1; f >= 0; f--) begin
      clr = (f == 0);
      for (int p = 0; p < 4; p++) begin
        ptr_set = p[1:0];
        cyc();
        idle();
        bd = 1'b1;
        cyc();
        idle();
        if (p[1:0] != PTR_FULL || f == 1) begin
          chk(na, {2'b01, f[0], p[0], goto[7:0]});
          chk(done, 1'b0);
        end else begin
          chk(na, {goto[11:8], fb[7:4], fb[3:0] | goto[3:0]});
          chk(done, 1'b1);
        end
      end
    end
    // forced dispatch ignores flag and empty pointer
    {irq, ptr_set, goto} = {1'b1, PTR_EMPTY, 12'h300};
    cyc();
    idle();
    fbd = 1'b1;
    cyc();
    idle();
    chk(na, {4'h3, fb});
    chk(done, 1'b1);
    {mal, pgc} = 2'b11;
    cyc();
    idle();
    bd = 1'b1;
    cyc();
    idle();
    chk(na, goto);
    chk(done, 1'b0);
    // parity in c1, then in c2
    to_phase(MTLC_C1);
    par = 1'b1;
    cyc();
    idle();
    chk(cpe, 1'b1);
    trap(TASK_KERNEL);
    chk(16'(n), 16'd2);
    to_phase(MTLC_C2);
    par = 1'b1;
    trap(TASK_KERNEL);
    chk(16'(n), 16'd5);
    rd_kind(EK_PARITY);
    // stack underflow, overflow, triple op
    to_phase(MTLC_C2);
    xp = 1'b1;
    trap(TASK_EMU);
    chk(16'(n), 16'd5);
    chk(si, STK_TOP);
    rd_kind(EK_PARITY);
    clr = 1'b1;
    cyc();
    idle();
    psh = 1'b1;
    trap(TASK_EMU);
    chk(si, STK_BOTTOM);
    chk(16'(n), 16'd4);
    psh = 1'b1;
    cyc();
    idle();
    {xp, zp, psh} = 3'b111;
    trap(TASK_EMU);
    chk(si, STK_NEXT);
    rd_kind(EK_STACK);
    // memory error for the emulator, then for a device task
    merr = 1'b1;
    trap(TASK_EMU);
    chk(16'(n), 16'd5);
    rd_kind(EK_MEMORY);
    // device error: emulator clicks follow, still no trap and no kind
    {tsk, clr} = {3'h3, 1'b1};
    cyc();
    idle();
    {merr, nt} = 2'b10;
    for (int i = 0; i < 24; i++) begin
      cyc();
      idle();
      nt = nt | tv;
      if (i == 11) tsk = TASK_EMU;
    end
    chk(nt, 1'b0);
    rd_kind(EK_BUFFER);
    // buffer read while empty, raised in c1
    to_phase(MTLC_C1);
    brd = 1'b1;
    trap(TASK_EMU);
    chk(16'(n), 16'd3);
    rd_kind(EK_BUFFER);
    results();
  end
endmodule
